/* File: shared/rsseq_pkg.sv */
package rsseq_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned T_POR_INIT_NS  = 92000;
   localparam int unsigned POR_INIT_CYC   = (T_POR_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_PER_US     = 1000 / CLK_PERIOD_NS;
   localparam int unsigned CNT_W          = 20;
   localparam logic [4:0]  PULSE_LONG_CYC = 5'h10;
   localparam logic [4:0]  PULSE_SHORT_CYC = 5'h02;

   // Start-up delays in microseconds (16, 512, 1024, 4096 / 1024, 2048, 4096, 16384)
   localparam logic [14:0] SUT_US_RC0 = 15'h0010;
   localparam logic [14:0] SUT_US_RC1 = 15'h0200;
   localparam logic [14:0] SUT_US_RC2 = 15'h0400;
   localparam logic [14:0] SUT_US_RC3 = 15'h1000;
   localparam logic [14:0] SUT_US_XT0 = 15'h0400;
   localparam logic [14:0] SUT_US_XT1 = 15'h0800;
   localparam logic [14:0] SUT_US_XT2 = 15'h1000;
   localparam logic [14:0] SUT_US_XT3 = 15'h4000;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADDR_PWR_CTRL = 8'h00;
   localparam logic [7:0]  ADDR_WDT_CTRL = 8'h04;
   localparam logic [7:0]  ADDR_WDT_RST  = 8'h08;
   localparam logic [7:0]  ADDR_SW_KEY   = 8'h0C;
   localparam logic [7:0]  ADDR_STATUS   = 8'h10;
   localparam int unsigned COLD_BIT      = 4;
   localparam int unsigned OVF_BIT       = 0;
   localparam int unsigned SWF_BIT       = 1;
   localparam logic [7:0]  WDT_KEY1      = 8'h1E;
   localparam logic [7:0]  WDT_KEY2      = 8'hE1;
   localparam logic [7:0]  SW_KEY1       = 8'h5A;
   localparam logic [7:0]  SW_KEY2       = 8'hA5;
   localparam logic [15:0] RESET_VECTOR  = 16'h0000;

   typedef enum logic [6:0] {
      ST_INIT  = 7'h01,
      ST_WBOD  = 7'h02,
      ST_SUT   = 7'h04,
      ST_PINH  = 7'h08,
      ST_RUN   = 7'h10,
      ST_BODL  = 7'h20,
      ST_PULSE = 7'h40
   } rsseq_state_t;

   typedef struct packed {
      logic [1:0] startup_time_fuses;
      logic       xtal;
      logic       bod_en;
      logic       rst_en;
   } rsseq_fuse_t;
endpackage

/* File: hw/rsseq_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - During reset, tristate port pins; execution restarts at vector 0000H.
// - Power-on, brown-out, pin, watchdog and software key merge into one reset.
// - After supply good, run the 92 us init, then the start-up timer.
// - Supply below power-on threshold reasserts reset at once.
// - A power-on reset sets the cold start flag.
// - Pin still low at start-up end keeps reset until it rises.
// - With brown-out on, start-up waits for both threshold crossing and init.
// - Two fuses and clock type select the start-up delay.
// - Same delay serves brown-out release and timed power-down wake.
// - Brown-out asserts reset at once, releases after start-up delay.
// - Brown-out acts only when its enable fuse is set.
// - Fuse set: pin is active-low reset; cleared: plain I/O.
// - Pin must be low two clocks to trigger reset.
// - During power-up the pin always acts as reset input.
// - Only power-up overrides the pin fuse; other resets do not.
// - Programming entry enabled while pin low; fuse off means power-up only.
// - Watchdog time-out gives 16-cycle reset and sets overflow flag.
// - Watchdog restarts only on ordered write pair 1EH then E1H.
// - Key pair 5AH then A5H gives 16-cycle reset and software flag.
// - Cold start flag untouched by warm resets; software may change it.
// - Pin wake from power-down released early yields a two-cycle reset.
module rsseq_top #(
   parameter int unsigned POR_INIT_CYC = rsseq_pkg::POR_INIT_CYC,
   parameter int unsigned CYC_PER_US   = rsseq_pkg::CYC_PER_US
) (
   input  wire logic                  pclk,          // System clock
   input  wire logic                  presetn,       // Async reset, active low
   input  wire logic                  psel,          // APB select
   input  wire logic                  penable,       // APB enable
   input  wire logic                  pwrite,        // APB direction
   input  wire logic [7:0]            paddr,         // APB byte address
   input  wire logic [31:0]           pwdata,        // APB write data
   output logic      [31:0]           prdata,        // APB read data
   output logic                       pready,        // APB ready
   output logic                       pslverr,       // APB error, unmapped
   input  wire logic                  por_ok_i,      // Supply above power-on level, async
   input  wire logic                  bod_ok_i,      // Supply above brown-out level, async
   input  wire rsseq_pkg::rsseq_fuse_t fuse_i,       // Configuration fuses
   input  wire logic                  wdt_timeout_i, // Watchdog time-out pulse
   input  wire logic                  pd_mode_i,     // Device is in power-down
   input  wire logic                  pd_wake_i,     // Interrupt wake, timed mode
   input  wire logic                  pin_i,         // Shared reset pin level
   output logic                       pin_o,         // Shared pin output value
   output logic                       pin_oe,        // Shared pin output enable
   input  wire logic                  gpio_out_i,    // Port data for the pin
   input  wire logic                  gpio_oe_i,     // Port drive request
   output logic                       gpio_in_o,     // Pin level as port input
   output logic                       sys_rst_o,     // Internal reset, active high
   output logic                       cpu_clk_en_o,  // CPU clock may run
   output logic      [15:0]           reset_vector_o, // Start address after reset
   output logic                       wdt_restart_o, // Watchdog restart pulse
   output logic                       isp_en_o       // Programming entry allowed
);
   // ----------------------------------------------------------------
   // Synchronisers and raw sources
   // ----------------------------------------------------------------
   logic por_s1_q, por_s2_q, bod_s1_q, bod_s2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_s1_q <= 1'b0;
         por_s2_q <= 1'b0;
         bod_s1_q <= 1'b0;
         bod_s2_q <= 1'b0;
      end else begin
         por_s1_q <= por_ok_i;
         por_s2_q <= por_s1_q;
         bod_s1_q <= bod_ok_i;
         bod_s2_q <= bod_s1_q;
      end
   end

   rsseq_pkg::rsseq_state_t st_q, st_d;
   logic [rsseq_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [4:0] plen_q, plen_d;
   logic       powerup_q, wake_q, pinwake_q, pin_lo_q;
   logic       wd_arm_q, sw_arm_q, cold_q, ovf_q, swf_q;

   wire bod_use  = fuse_i.bod_en && !pd_mode_i;
   wire por_raw  = !por_ok_i;
   wire bod_raw  = bod_use && !bod_ok_i;
   wire bod_low  = bod_use && !bod_s2_q;
   wire rst_fn   = fuse_i.rst_en || powerup_q;
   wire ext_rst  = rst_fn && !pin_i && pin_lo_q;
   wire in_run   = (st_q == rsseq_pkg::ST_RUN);

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   wire        wr_en   = psel && penable && pwrite;
   wire [7:0]  wbyte   = pwdata[7:0];
   wire        sel_pwr = (paddr == rsseq_pkg::ADDR_PWR_CTRL);
   wire        sel_wdc = (paddr == rsseq_pkg::ADDR_WDT_CTRL);
   wire        sel_wdr = (paddr == rsseq_pkg::ADDR_WDT_RST);
   wire        sel_swk = (paddr == rsseq_pkg::ADDR_SW_KEY);
   wire        sel_sts = (paddr == rsseq_pkg::ADDR_STATUS);
   wire        mapped  = sel_pwr || sel_wdc || sel_wdr || sel_swk || sel_sts;
   wire        wd_fire = wr_en && sel_wdr && wd_arm_q && (wbyte == rsseq_pkg::WDT_KEY2);
   wire        sw_fire = wr_en && sel_swk && sw_arm_q && (wbyte == rsseq_pkg::SW_KEY2);

   // Any write other than the matching first byte disarms, so a pair
   // split by an unrelated write never counts.
   function automatic logic arm_next(input logic wr, input logic sel, input logic [7:0] b,
                                     input logic [7:0] key1, input logic arm);
      arm_next = wr ? (sel && (b == key1)) : arm;
   endfunction

   function automatic logic flag_next(input logic q, input logic wr, input logic wb, input logic set);
      flag_next = (wr ? wb : q) || set;
   endfunction

   logic [31:0] rdata_d;
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (sel_pwr) rdata_d[rsseq_pkg::COLD_BIT] = cold_q;
      if (sel_wdc) begin
         rdata_d[rsseq_pkg::OVF_BIT] = ovf_q;
         rdata_d[rsseq_pkg::SWF_BIT] = swf_q;
      end
      if (sel_sts) rdata_d[6:0] = st_q;
   end

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata   <= 32'h0000_0000;
         wd_arm_q <= 1'b0;
         sw_arm_q <= 1'b0;
         cold_q   <= 1'b0;
         ovf_q    <= 1'b0;
         swf_q    <= 1'b0;
      end else begin
         if (psel && !penable) prdata <= rdata_d;
         wd_arm_q <= arm_next(wr_en, sel_wdr, wbyte, rsseq_pkg::WDT_KEY1, wd_arm_q);
         sw_arm_q <= arm_next(wr_en, sel_swk, wbyte, rsseq_pkg::SW_KEY1, sw_arm_q);
         // Hardware set wins over a software clear in the same cycle
         cold_q <= flag_next(cold_q, wr_en && sel_pwr, pwdata[rsseq_pkg::COLD_BIT],
                             st_q == rsseq_pkg::ST_INIT);
         ovf_q  <= flag_next(ovf_q, wr_en && sel_wdc, pwdata[rsseq_pkg::OVF_BIT],
                             wdt_timeout_i && in_run);
         swf_q  <= flag_next(swf_q, wr_en && sel_wdc, pwdata[rsseq_pkg::SWF_BIT], sw_fire);
      end
   end

   // ----------------------------------------------------------------
   // Start-up delay selection
   // ----------------------------------------------------------------
   function automatic logic [14:0] sut_us(input logic [1:0] s, input logic xt);
      unique case ({xt, s})
         3'b000:  sut_us = rsseq_pkg::SUT_US_RC0;
         3'b001:  sut_us = rsseq_pkg::SUT_US_RC1;
         3'b010:  sut_us = rsseq_pkg::SUT_US_RC2;
         3'b011:  sut_us = rsseq_pkg::SUT_US_RC3;
         3'b100:  sut_us = rsseq_pkg::SUT_US_XT0;
         3'b101:  sut_us = rsseq_pkg::SUT_US_XT1;
         3'b110:  sut_us = rsseq_pkg::SUT_US_XT2;
         default: sut_us = rsseq_pkg::SUT_US_XT3;
      endcase
   endfunction

   wire [31:0] sut_prod = 32'(sut_us(fuse_i.startup_time_fuses, fuse_i.xtal)) * 32'(CYC_PER_US);
   wire [rsseq_pkg::CNT_W-1:0] sut_last  = rsseq_pkg::CNT_W'(sut_prod - 32'h0000_0001);
   wire [rsseq_pkg::CNT_W-1:0] init_last = rsseq_pkg::CNT_W'(POR_INIT_CYC - 1);
   wire [rsseq_pkg::CNT_W-1:0] cnt_inc   = cnt_q + 1'b1;
   wire pin_wake = in_run && pd_mode_i && rst_fn && !pin_i;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_inc;
      plen_d = plen_q;
      unique case (st_q)
         rsseq_pkg::ST_INIT: begin
            if (cnt_q == init_last) begin
               cnt_d = '0;
               st_d  = bod_low ? rsseq_pkg::ST_WBOD : rsseq_pkg::ST_SUT;
            end
         end
         rsseq_pkg::ST_WBOD: begin
            cnt_d = '0;
            if (!bod_low) st_d = rsseq_pkg::ST_SUT;
         end
         rsseq_pkg::ST_SUT: begin
            if (cnt_q == sut_last) begin
               cnt_d = '0;
               if ((powerup_q || pinwake_q) && !pin_i) begin
                  st_d = rsseq_pkg::ST_PINH;
               end else if (pinwake_q) begin
                  st_d   = rsseq_pkg::ST_PULSE;
                  plen_d = rsseq_pkg::PULSE_SHORT_CYC;
               end else begin
                  st_d = rsseq_pkg::ST_RUN;
               end
            end
         end
         rsseq_pkg::ST_PINH: begin
            cnt_d = '0;
            if (pin_i) st_d = rsseq_pkg::ST_RUN;
         end
         rsseq_pkg::ST_RUN: begin
            cnt_d = '0;
            if (wdt_timeout_i || sw_fire) begin
               st_d   = rsseq_pkg::ST_PULSE;
               plen_d = rsseq_pkg::PULSE_LONG_CYC;
            end else if (pd_wake_i || pin_wake) begin
               st_d = rsseq_pkg::ST_SUT;
            end
         end
         rsseq_pkg::ST_BODL: begin
            cnt_d = '0;
            if (!bod_low) st_d = rsseq_pkg::ST_SUT;
         end
         rsseq_pkg::ST_PULSE: begin
            if (cnt_q == rsseq_pkg::CNT_W'(plen_q - 5'h01)) begin
               cnt_d = '0;
               st_d  = rsseq_pkg::ST_RUN;
            end
         end
         default: begin
            cnt_d = '0;
            st_d  = rsseq_pkg::ST_INIT;
         end
      endcase
      if (bod_low && st_q != rsseq_pkg::ST_INIT && st_q != rsseq_pkg::ST_WBOD
          && st_q != rsseq_pkg::ST_BODL) begin
         cnt_d = '0;
         st_d  = rsseq_pkg::ST_BODL;
      end
      if (!por_s2_q) begin
         cnt_d = '0;
         st_d  = rsseq_pkg::ST_INIT;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q      <= rsseq_pkg::ST_INIT;
         cnt_q     <= '0;
         plen_q    <= rsseq_pkg::PULSE_LONG_CYC;
         powerup_q <= 1'b1;
         wake_q    <= 1'b0;
         pinwake_q <= 1'b0;
         pin_lo_q  <= 1'b0;
         gpio_in_o <= 1'b1;
      end else begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         plen_q    <= plen_d;
         powerup_q <= (st_d == rsseq_pkg::ST_INIT) || (powerup_q && st_d != rsseq_pkg::ST_RUN);
         wake_q    <= (in_run && st_d == rsseq_pkg::ST_SUT) || (wake_q && st_d == rsseq_pkg::ST_SUT);
         pinwake_q <= (pin_wake && st_d == rsseq_pkg::ST_SUT) || (pinwake_q && st_d == rsseq_pkg::ST_SUT);
         pin_lo_q  <= !pin_i;
         gpio_in_o <= pin_i;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // A timed wake holds the CPU clock but not the reset
   wire seq_rst = !in_run && !(st_q == rsseq_pkg::ST_SUT && wake_q);
   assign sys_rst_o      = por_raw || bod_raw || ext_rst || seq_rst;
   assign cpu_clk_en_o   = in_run && !sys_rst_o;
   assign reset_vector_o = rsseq_pkg::RESET_VECTOR;
   assign pin_o          = gpio_out_i;
   assign pin_oe         = gpio_oe_i && !rst_fn && !sys_rst_o;
   assign wdt_restart_o  = wd_fire;
   assign isp_en_o       = !pin_i && rst_fn;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_rst8;
      sys_rst_o [*8];
   endsequence

   property p_pulse16;
      (in_run && !bod_low && por_s2_q && (wdt_timeout_i || sw_fire))
         |=> s_rst8 ##1 s_rst8;
   endproperty
   a_pulse16: assert property (p_pulse16) else $error("Pulse reset shorter than 16 cycles");

   property p_por_now;
      !por_ok_i |-> sys_rst_o;
   endproperty
   a_por_now: assert property (p_por_now) else $error("Reset missing while supply low");

   property p_bod_now;
      (fuse_i.bod_en && !pd_mode_i && !bod_ok_i) |-> sys_rst_o;
   endproperty
   a_bod_now: assert property (p_bod_now) else $error("Reset missing on brown-out");

   property p_bod_off;
      (!fuse_i.bod_en && in_run && por_s2_q && !wdt_timeout_i && !sw_fire && !pd_wake_i && !pin_wake)
         |=> in_run;
   endproperty
   a_bod_off: assert property (p_bod_off) else $error("Brown-out acted with fuse off");

   property p_cold;
      (st_q == rsseq_pkg::ST_INIT) |=> cold_q;
   endproperty
   a_cold: assert property (p_cold) else $error("Cold flag not set on power-on");

   property p_pin2;
      (fuse_i.rst_en && !pin_i && $past(!pin_i)) |-> sys_rst_o;
   endproperty
   a_pin2: assert property (p_pin2) else $error("Pin low two cycles gave no reset");

   property p_tri;
      sys_rst_o |-> !pin_oe;
   endproperty
   a_tri: assert property (p_tri) else $error("Pin driven during reset");

   property p_pinhold;
      (st_q == rsseq_pkg::ST_PINH && !pin_i && por_s2_q && !bod_low) |=> (st_q == rsseq_pkg::ST_PINH);
   endproperty
   a_pinhold: assert property (p_pinhold) else $error("Left pin hold while pin low");

   // Access phases of two APB writes are at least two clocks apart
   sequence s_swk1;
      wr_en && sel_swk && wbyte == rsseq_pkg::SW_KEY1;
   endsequence

   sequence s_swk2;
      wr_en && sel_swk && wbyte == rsseq_pkg::SW_KEY2;
   endsequence

   property p_swkey;
      s_swk1 ##[2:3] s_swk2 |=> swf_q;
   endproperty
   a_swkey: assert property (p_swkey) else $error("Key pair did not set software flag");

   property p_disarm;
      (wr_en && sel_wdr && wbyte != rsseq_pkg::WDT_KEY1) |=> !wd_arm_q;
   endproperty
   a_disarm: assert property (p_disarm) else $error("Bad byte left sequence armed");
endmodule

/* File: tb/rsseq_pin_model.sv */
`timescale 1ns/1ps
module rsseq_pin_model (
   input  wire logic pclk,     // System clock
   input  wire logic hold_req, // Pull the pin low while high
   input  wire logic glitch,   // One-cycle low, too short on purpose
   input  wire logic pin_o,    // Device drive value
   input  wire logic pin_oe,   // Device drive enable
   output logic      pin_lvl   // Resolved pin level
);
   logic [1:0] min_q = 2'h0;

   // A real reset circuit never lets go after a single clock
   always_ff @(posedge pclk) begin
      if (hold_req) begin
         min_q <= 2'h2;
      end else if (min_q != 2'h0) begin
         min_q <= min_q - 2'h1;
      end
   end

   wire drive_low = hold_req || (min_q != 2'h0) || glitch;
   // Pull-up on the pin; held low at power-on only when a test commands it
   assign pin_lvl = pin_oe ? pin_o : !drive_low;
endmodule

/* File: tb/tb_reset_source_sequencer.sv */
`timescale 1ns/1ps
module tb_reset_source_sequencer;
   localparam int unsigned POR_CYC = 20;
   logic                   pclk, presetn, psel, penable, pwrite, por_ok, bod_ok;
   logic                   wdt_to, gpio_out, gpio_oe, hold_req, glitch, pin_lvl;
   logic                   pready, pslverr, pin_o, pin_oe, gpio_in, sys_rst;
   logic                   clk_en, wdt_rs, isp_en, err, rs, pd_mode, pd_wake;
   logic [7:0]             paddr, b;
   logic [31:0]            pwdata, prdata, rd;
   logic [15:0]            rvec;
   rsseq_pkg::rsseq_fuse_t fuse;
   int                     n_mismatch, num_checks, n;

   rsseq_top #(.POR_INIT_CYC(POR_CYC), .CYC_PER_US(1)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .por_ok_i(por_ok), .bod_ok_i(bod_ok), .fuse_i(fuse), .wdt_timeout_i(wdt_to),
      .pd_mode_i(pd_mode), .pd_wake_i(pd_wake), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe(pin_oe),
      .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in), .sys_rst_o(sys_rst),
      .cpu_clk_en_o(clk_en), .reset_vector_o(rvec), .wdt_restart_o(wdt_rs), .isp_en_o(isp_en));
   rsseq_pin_model ext (
      .pclk(pclk), .hold_req(hold_req), .glitch(glitch), .pin_o(pin_o), .pin_oe(pin_oe),
      .pin_lvl(pin_lvl));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic int sut_cyc(input int i);
      int t [8] = '{16, 512, 1024, 4096, 1024, 2048, 4096, 16384};
      return t[i];
   endfunction
   task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_range(input string what, input int lo, input int hi, input int g);
      num_checks++;
      if (g < lo || g > hi) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // Starts at a falling edge; counts falling edges with sys_rst at lvl
   task automatic count_while(input logic lvl, input int lim);
      n = 0;
      while (sys_rst === lvl && n < lim) begin
         n++;
         @(negedge pclk);
      end
   endtask
   // Same, counting falling edges while the CPU clock is held
   task automatic count_clk(input int lim);
      n = 0;
      while (clk_en === 1'b0 && n < lim) begin
         n++;
         @(negedge pclk);
      end
   endtask
   // Setup, then access until pready; the answer is taken at that same edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      rs      = wdt_rs;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk_reg(input string what, input logic [7:0] a, input int unsigned i, input logic e);
      apb(1'b0, a, 32'h0000_0000);
      chk_val(what, 32'(e), 32'(rd[i]));
   endtask
   task automatic power_up(input logic [4:0] f, input logic hold);
      @(posedge pclk);
      presetn  <= 1'b0;
      por_ok   <= 1'b0;
      fuse     <= rsseq_pkg::rsseq_fuse_t'(f);
      hold_req <= hold;
      gpio_oe  <= 1'b1;
      gpio_out <= 1'b1;
      cyc(8);
      chk_val("pin drive in reset", 32'h0000_0000, 32'(pin_oe));
      presetn  <= 1'b1;
      por_ok   <= 1'b1;
      @(negedge pclk);
      count_while(1'b1, 20000);
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // Longest path is the eight start-up delays, about 30000 cycles
   initial begin
      cyc(80000);
      n_mismatch++;
      $display("MISMATCH run time expected finish seen hang");
      test_done();
   end
   initial begin
      {presetn, psel, penable, pwrite, por_ok, wdt_to, gpio_out, hold_req, glitch, pd_mode, pd_wake} = '0;
      {bod_ok, gpio_oe} = 2'h3;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      fuse = '0;
      n_mismatch = 0;
      num_checks = 0;
      n = $urandom(82480);
      for (int i = 0; i < 8; i++) begin
         power_up({i[1:0], i[2], 2'h1}, 1'b0);
         chk_range("start-up cycles", POR_CYC + sut_cyc(i), POR_CYC + sut_cyc(i) + 8, n);
      end
      chk_val("reset vector", 32'h0000_0000, 32'(rvec));
      chk_reg("cold flag", rsseq_pkg::ADDR_PWR_CTRL, rsseq_pkg::COLD_BIT, 1'b1);
      $display("test start-up delays done");
      fork
         power_up(5'h00, 1'b1);
         begin
            cyc(200);
            chk_val("prog entry", 32'h0000_0001, 32'(isp_en));
            chk_val("held reset", 32'h0000_0001, 32'(sys_rst));
            hold_req <= 1'b0;
         end
      join
      chk_range("pin release", 188, 200, n);
      for (int i = 0; i < 16; i++) begin
         cyc(1);
         gpio_out <= 1'($urandom);
         gpio_oe  <= 1'($urandom);
         hold_req <= 1'($urandom);
         cyc(5);
         chk_val("pin drive", 32'({gpio_oe, gpio_out}), 32'({pin_oe, pin_o}));
         chk_val("port input", 32'(gpio_oe ? gpio_out : !hold_req), 32'(gpio_in));
         chk_val("run state", 32'h0000_0001, 32'({sys_rst, clk_en}));
      end
      $display("test pin as port done");
      power_up(5'h03, 1'b0);
      cyc(1);
      gpio_oe <= 1'b0;
      glitch  <= 1'b1;
      cyc(1);
      glitch  <= 1'b0;
      @(negedge pclk);
      count_while(1'b0, 8);
      chk_range("short pin pulse", 8, 8, n);
      cyc(1);
      hold_req <= 1'b1;
      @(negedge pclk);
      count_while(1'b0, 8);
      chk_range("pin reset delay", 1, 5, n);
      cyc(1);
      hold_req <= 1'b0;
      @(negedge pclk);
      count_while(1'b1, 500);
      cyc(1);
      wdt_to <= 1'b1;
      cyc(1);
      wdt_to <= 1'b0;
      @(negedge pclk);
      count_while(1'b1, 40);
      chk_range("watchdog pulse", 16, 16, n);
      chk_reg("overflow flag", rsseq_pkg::ADDR_WDT_CTRL, rsseq_pkg::OVF_BIT, 1'b1);
      chk_reg("cold after warm", rsseq_pkg::ADDR_PWR_CTRL, rsseq_pkg::COLD_BIT, 1'b1);
      $display("test pin and watchdog done");
      b = 8'($urandom);
      if (b == rsseq_pkg::SW_KEY1 || b == rsseq_pkg::SW_KEY2) b = 8'h00;
      apb(1'b1, rsseq_pkg::ADDR_SW_KEY, 32'(rsseq_pkg::SW_KEY1));
      apb(1'b1, rsseq_pkg::ADDR_SW_KEY, 32'(b));
      apb(1'b1, rsseq_pkg::ADDR_SW_KEY, 32'(rsseq_pkg::SW_KEY2));
      @(negedge pclk);
      count_while(1'b0, 20);
      chk_range("broken key", 20, 20, n);
      apb(1'b1, rsseq_pkg::ADDR_SW_KEY, 32'(rsseq_pkg::SW_KEY1));
      apb(1'b1, rsseq_pkg::ADDR_SW_KEY, 32'(rsseq_pkg::SW_KEY2));
      @(negedge pclk);
      count_while(1'b0, 4);
      count_while(1'b1, 40);
      chk_range("software pulse", 16, 16, n);
      chk_reg("software flag", rsseq_pkg::ADDR_WDT_CTRL, rsseq_pkg::SWF_BIT, 1'b1);
      apb(1'b1, rsseq_pkg::ADDR_WDT_RST, 32'(rsseq_pkg::WDT_KEY1));
      apb(1'b1, rsseq_pkg::ADDR_WDT_RST, 32'(rsseq_pkg::WDT_KEY2));
      chk_val("restart on pair", 32'h0000_0001, 32'(rs));
      apb(1'b1, rsseq_pkg::ADDR_WDT_RST, 32'(rsseq_pkg::WDT_KEY2));
      chk_val("restart on lone byte", 32'h0000_0000, 32'(rs));
      apb(1'b1, rsseq_pkg::ADDR_PWR_CTRL, 32'h0000_0000);
      chk_reg("cold cleared", rsseq_pkg::ADDR_PWR_CTRL, rsseq_pkg::COLD_BIT, 1'b0);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk_val("unmapped error", 32'h0000_0001, 32'(err));
      chk_val("unmapped data", 32'h0000_0000, rd);
      $display("test keys done");
      cyc(1);
      bod_ok <= 1'b0;
      @(negedge pclk);
      chk_val("brown-out reset", 32'h0000_0001, 32'(sys_rst));
      cyc(4);
      bod_ok <= 1'b1;
      @(negedge pclk);
      count_while(1'b1, 500);
      chk_range("brown-out release", 16, 24, n);
      chk_reg("cold after brown-out", rsseq_pkg::ADDR_PWR_CTRL, rsseq_pkg::COLD_BIT, 1'b0);
      cyc(1);
      fuse.bod_en <= 1'b0;
      bod_ok <= 1'b0;
      @(negedge pclk);
      count_while(1'b0, 10);
      chk_range("brown-out fuse off", 10, 10, n);
      cyc(1);
      bod_ok <= 1'b1;
      por_ok <= 1'b0;
      @(negedge pclk);
      chk_val("power-on drop", 32'h0000_0001, 32'(sys_rst));
      cyc(4);
      por_ok <= 1'b1;
      @(negedge pclk);
      count_while(1'b1, 500);
      chk_range("power-on restart", POR_CYC + 16, POR_CYC + 26, n);
      chk_reg("cold after power-on", rsseq_pkg::ADDR_PWR_CTRL, rsseq_pkg::COLD_BIT, 1'b1);
      $display("test supply detectors done");
      cyc(1);
      pd_wake <= 1'b1;
      cyc(1);
      pd_wake <= 1'b0;
      @(negedge pclk);
      chk_val("timed wake reset", 32'h0000_0000, 32'(sys_rst));
      count_clk(40);
      chk_range("timed wake", sut_cyc(0), sut_cyc(0), n);
      cyc(1);
      pd_mode  <= 1'b1;
      hold_req <= 1'b1;
      cyc(1);
      hold_req <= 1'b0;
      @(negedge pclk);
      count_while(1'b1, 40);
      count_while(1'b0, 40);
      chk_range("pin wake run-up", sut_cyc(0) - 4, sut_cyc(0), n);
      count_while(1'b1, 40);
      chk_range("pin wake pulse", 2, 2, n);
      cyc(1);
      pd_mode <= 1'b0;
      $display("test power-down wake done");
      test_done();
   end
endmodule
